// ---- rtl/bbsr_top.sv ----
// Eight-stage bidirectional bus register with serial path and AHB-Lite control.
// Assumes pins A, B, serial input and shift clock are asynchronous to CLK.
//
// Operation
// - Eight stages, two parallel bidirectional ports
// - A port used only while enabled
// - Direction one: A in, B out
// - Synchronous parallel load on shift clock rise
// - Asynchronous parallel load follows input continuously
// - Serial mode ignores async select, always synchronous
// - Parallel select loads from current input port
// - Serial select shifts data on clock rise
// - Shift clock ignored in asynchronous parallel mode
// - Stage update follows clock or asynchronous path
// - Only the selected output port drives
`timescale 1ns/100ps

module bbsr_top
  import bbsr_pkg::*;
#(
  parameter int STAGES = BBSR_STAGES
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SHIFT_CLK,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  input wire logic [STAGES-1:0] A_IN,
  output logic [STAGES-1:0] A_OUT,
  output logic [STAGES-1:0] A_OE,
  input wire logic [STAGES-1:0] B_IN,
  output logic [STAGES-1:0] B_OUT,
  output logic [STAGES-1:0] B_OE
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // Reset value and register map are laid out for eight stages
  if (STAGES != BBSR_STAGES) begin : g_stages_bad
    $error("STAGES must be 8");
  end

  // Pin synchronisers below are built two flip-flops deep
  if (BBSR_SYNC_DEPTH != 2) begin : g_sync_bad
    $error("Synchroniser depth must be 2");
  end

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [STAGES-1:0] a_sync;
  logic [STAGES-1:0] b_sync;
  logic sin_meta_reg;
  logic sin_sync_reg;
  logic sclk_meta_reg;
  logic sclk_sync_reg;
  logic sclk_prev_reg;

  // Parallel port pins, one synchroniser per line
  for (genvar i = 0; i < STAGES; i++) begin : g_pin_sync
    logic a_meta_reg;
    logic a_sync_reg;
    logic b_meta_reg;
    logic b_sync_reg;

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        a_meta_reg <= 1'b0;
        a_sync_reg <= 1'b0;
      end else begin
        a_meta_reg <= A_IN[i];
        a_sync_reg <= a_meta_reg;
      end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        b_meta_reg <= 1'b0;
        b_sync_reg <= 1'b0;
      end else begin
        b_meta_reg <= B_IN[i];
        b_sync_reg <= b_meta_reg;
      end
    end

    assign a_sync[i] = a_sync_reg;
    assign b_sync[i] = b_sync_reg;
  end

  // Serial data pin
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sin_meta_reg <= 1'b0;
      sin_sync_reg <= 1'b0;
    end else begin
      sin_meta_reg <= SERIAL_IN;
      sin_sync_reg <= sin_meta_reg;
    end
  end

  // Shift clock pin and its edge history; idle level is low
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_meta_reg <= SHIFT_CLK;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  logic [BBSR_CTRL_WIDTH-1:0] ctrl_reg;
  logic [STAGES-1:0] stage_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic addr_valid;

  function automatic logic [31:0] read_word(input logic [7:0] ofs,
                                            input logic [BBSR_CTRL_WIDTH-1:0] ctrl,
                                            input logic [STAGES-1:0] data,
                                            input logic sclk,
                                            input logic sout);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (ofs)
      BBSR_CTRL_OFS: w[BBSR_CTRL_WIDTH-1:0] = ctrl;
      BBSR_DATA_OFS: w[STAGES-1:0] = data;
      BBSR_STAT_OFS: begin
        w[BBSR_STAT_SCLK_BIT] = sclk;
        w[BBSR_STAT_SOUT_BIT] = sout;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  logic rd_take;
  logic wr_take;
  logic ctrl_wr;

  // A transfer is taken in its address phase; HSIZE is not decoded
  assign addr_valid = HSEL && HREADY && HTRANS[1];
  assign rd_take = addr_valid && !HWRITE;
  assign wr_take = addr_valid && HWRITE;

  // Write request waits one cycle for its data phase
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_take;
    end
  end

  // Address of the pending write
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_addr_reg <= 8'h00;
    end else if (wr_take) begin
      wr_addr_reg <= HADDR[7:0];
    end
  end

  // Only the control register accepts writes
  assign ctrl_wr = wr_pend_reg && (wr_addr_reg == BBSR_CTRL_OFS);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_reg <= read_word(HADDR[7:0], ctrl_reg, stage_reg, sclk_sync_reg,
                             stage_reg[STAGES-1]);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg <= BBSR_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= HWDATA[BBSR_CTRL_WIDTH-1:0];
    end
  end

  assign HRDATA = rdata_reg;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ------------------------------------------------------------
  // Control decode
  // ------------------------------------------------------------
  logic a_en;
  logic dir_a_to_b;
  logic async_sel;
  logic par_sel;
  logic clk_rise;
  logic in_valid;
  logic par_load;
  logic ser_shift;
  logic [STAGES-1:0] par_in;
  logic [STAGES-1:0] shift_in;
  logic [STAGES-1:0] stage_next;

  assign a_en = ctrl_reg[BBSR_CTRL_AEN_BIT];
  assign dir_a_to_b = ctrl_reg[BBSR_CTRL_DIR_BIT];
  assign async_sel = ctrl_reg[BBSR_CTRL_ASYNC_BIT];
  assign par_sel = ctrl_reg[BBSR_CTRL_PAR_BIT];
  assign clk_rise = sclk_sync_reg && !sclk_prev_reg;
  assign par_in = dir_a_to_b ? a_sync : b_sync;
  assign in_valid = dir_a_to_b ? a_en : 1'b1;
  // Asynchronous parallel mode copies the input on every CLK edge
  assign par_load = par_sel && in_valid && (async_sel || clk_rise);
  // Serial mode shifts on the shift clock alone
  assign ser_shift = !par_sel && clk_rise;
  assign shift_in = {stage_reg[STAGES-2:0], sin_sync_reg};

  // ------------------------------------------------------------
  // Register stages
  // ------------------------------------------------------------
  function automatic logic pick_stage(input logic load,
                                      input logic shift,
                                      input logic par_bit,
                                      input logic shift_bit,
                                      input logic hold_bit);
    logic b;
    b = hold_bit;
    if (load) begin
      b = par_bit;
    end else if (shift) begin
      b = shift_bit;
    end
    return b;
  endfunction

  for (genvar i = 0; i < STAGES; i++) begin : g_stage
    assign stage_next[i] = pick_stage(par_load, ser_shift, par_in[i], shift_in[i],
                                      stage_reg[i]);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      stage_reg <= BBSR_DATA_RESET;
    end else begin
      stage_reg <= stage_next;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  logic a_drive;
  logic b_drive;

  // Only the output port drives; the input port stays released
  assign a_drive = a_en && !dir_a_to_b;
  assign b_drive = dir_a_to_b;
  assign A_OUT = stage_reg;
  assign B_OUT = stage_reg;
  assign A_OE = {STAGES{a_drive}};
  assign B_OE = {STAGES{b_drive}};
  assign SERIAL_OUT = stage_reg[STAGES-1];

endmodule

// ---- rtl/bbsr_pkg.sv ----
// Package for the bidirectional bus shift register: register map and field layout.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package bbsr_pkg;

  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] BBSR_CTRL_OFS = 8'h00;
  localparam logic [7:0] BBSR_DATA_OFS = 8'h04;
  localparam logic [7:0] BBSR_STAT_OFS = 8'h08;

  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int BBSR_CTRL_AEN_BIT = 0;
  localparam int BBSR_CTRL_DIR_BIT = 1;
  localparam int BBSR_CTRL_ASYNC_BIT = 2;
  localparam int BBSR_CTRL_PAR_BIT = 3;
  localparam int BBSR_CTRL_WIDTH = 4;
  localparam logic [3:0] BBSR_CTRL_RESET = 4'h0;

  // ------------------------------------------------------------
  // Status register fields
  // ------------------------------------------------------------
  localparam int BBSR_STAT_SCLK_BIT = 0;
  localparam int BBSR_STAT_SOUT_BIT = 1;

  // ------------------------------------------------------------
  // Defaults
  // ------------------------------------------------------------
  localparam int BBSR_STAGES = 8;
  localparam logic [7:0] BBSR_DATA_RESET = 8'h00;
  localparam int BBSR_SYNC_DEPTH = 2;

endpackage

// ---- sim/bbsr_far_bus.sv ----
// Far-side bus model: drives each A and B line that the device leaves free.
// Assumes per-bit output enables from the device.
`timescale 1ns/100ps
module bbsr_far_bus (
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] a_drv,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] b_drv,
  output logic [7:0] a_pin,
  output logic [7:0] b_pin
);
  // Drive values are held steady around every shift clock edge
  assign a_pin = (a_oe & a_out) | (~a_oe & a_drv);
  assign b_pin = (b_oe & b_out) | (~b_oe & b_drv);
endmodule

// ---- sim/bbsr_checker.sv ----
// Checker for the bus register, seeing only the top ports.
// Assumes one clock CLK and active-low RESETN.
`timescale 1ns/100ps
module bbsr_checker #(
  parameter int STAGES = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic SHIFT_CLK,
  input wire logic [STAGES-1:0] A_IN,
  input wire logic [STAGES-1:0] B_IN,
  input wire logic [STAGES-1:0] A_OUT,
  input wire logic [STAGES-1:0] A_OE,
  input wire logic [STAGES-1:0] B_OUT,
  input wire logic [STAGES-1:0] B_OE,
  input wire logic SERIAL_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire cwr = HSEL && HTRANS[1] && HWRITE && HADDR[7:0] == 8'h00;
  wire calm = !SHIFT_CLK && !HTRANS[1];
  logic cwr_d;
  logic par_seen;
  // Parallel select as last written, following the control write data phase
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cwr_d <= 1'b0;
      par_seen <= 1'b0;
    end else begin
      cwr_d <= cwr;
      if (cwr_d) par_seen <= HWDATA[3];
    end
  end
  bus_ok_a: assert property (HREADYOUT && !HRESP) else $error("bus answer");
  dir_drive_a: assert property (cwr ##1 1 |=> B_OE == {STAGES{$past(HWDATA[1])}})
    else $error("B drive");
  a_enable_a: assert property (cwr ##1 1 |=> A_OE == {STAGES{$past(HWDATA[1:0]) == 2'h1}})
    else $error("A drive");
  oe_excl_a: assert property (!(A_OE[0] && B_OE[0])) else $error("both drive");
  oe_whole_a: assert property (A_OE inside {'0, '1} && B_OE inside {'0, '1})
    else $error("split drive");
  ser_last_a: assert property (($rose(SHIFT_CLK) && !par_seen) ##3 1 |->
    A_OUT[STAGES-1:1] == $past(A_OUT[STAGES-2:0]) && SERIAL_OUT == A_OUT[STAGES-1])
    else $error("serial shift");
  ports_same_a: assert property (A_OUT == B_OUT) else $error("ports differ");
  quiet_hold_a: assert property ((calm && $stable(A_IN) && $stable(B_IN))[*6] |=> $stable(A_OUT))
    else $error("stage moved");
endmodule
bind bbsr_top bbsr_checker #(.STAGES(STAGES)) chk (.*);

// ---- sim/testbench.sv ----
// Testbench: bus tasks, far-side model, parallel and serial modes.
// Assumes the checker is bound to the design top.
`timescale 1ns/100ps
`define CK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, ex, sn); end end
module testbench;
  logic CLK = 1'h0, RESETN = 1'h0, HSEL = 1'h0, HWRITE = 1'h0, SHIFT_CLK = 1'h0;
  logic SERIAL_IN = 1'h0, HREADYOUT, HRESP, SERIAL_OUT;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, q;
  logic [7:0] A_IN, A_OUT, A_OE, B_IN, B_OUT, B_OE, v, st = 8'h00, ad = 8'h00;
  logic [3:0] md [5] = '{4'hB, 4'hF, 4'h9, 4'hA, 4'h8};
  wire HREADY = HREADYOUT;
  int error_cnt = 0, total_checks = 0;
  bbsr_top uut (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SHIFT_CLK(SHIFT_CLK), .SERIAL_IN(SERIAL_IN),
    .SERIAL_OUT(SERIAL_OUT), .A_IN(A_IN), .A_OUT(A_OUT), .A_OE(A_OE), .B_IN(B_IN),
    .B_OUT(B_OUT), .B_OE(B_OE));
  bbsr_far_bus far (.a_out(A_OUT), .a_oe(A_OE), .a_drv(ad), .b_out(B_OUT), .b_oe(B_OE),
    .b_drv(~ad), .a_pin(A_IN), .b_pin(B_IN));
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wrdy();
    int n;
    n = 0;
    do @(posedge CLK); while (HREADYOUT !== 1'h1 && ++n < 50);
    if (HREADYOUT !== 1'h1) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    wrdy();
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wrdy();
    q = HRDATA;
  endtask
  task automatic pulse();
    repeat (4) @(posedge CLK);
    SHIFT_CLK <= 1'h1;
    repeat (4) @(posedge CLK);
    SHIFT_CLK <= 1'h0;
    repeat (5) @(posedge CLK);
  endtask
  initial forever #10 CLK = ~CLK;
  initial begin
    void'($urandom(67366));
    repeat (6) @(posedge CLK);
    RESETN <= 1'h1;
    @(posedge CLK);
    `CK("a_oe", 8'h00, A_OE)
    bus(1'h0, 8'h0C, 32'h0);
    `CK("unmapped", 32'h0, q)
    foreach (md[i]) begin
      bus(1'h1, 8'h00, {28'h0, md[i]});
      bus(1'h0, 8'h00, 32'h0);
      `CK("ctrl", {28'h0, md[i]}, q)
      v = 8'($urandom);
      ad <= v;
      if (md[i][2]) repeat (13) @(posedge CLK);
      else pulse();
      st = md[i][1] ? (md[i][0] ? v : st) : ~v;
      bus(1'h0, 8'h04, 32'h0);
      `CK("data", {24'h0, st}, q)
      `CK("a_oe", {8{md[i][1:0] == 2'h1}}, A_OE)
      `CK("b_oe", {8{md[i][1]}}, B_OE)
    end
    bus(1'h1, 8'h00, 32'h4);
    repeat (9) begin
      v = 8'($urandom);
      SERIAL_IN <= v[0];
      ad <= v;
      pulse();
      st = {st[6:0], v[0]};
      `CK("ser_par", st, A_OUT)
      `CK("ser_out", st[7], SERIAL_OUT)
      `CK("b_out", st, B_OUT)
    end
    bus(1'h0, 8'h08, 32'h0);
    `CK("stat", {30'h0, st[7], 1'h0}, q)
    conclude();
  end
endmodule
